/* hw/bac_pkg.sv */
package bac_pkg;

   localparam logic [15:0] ON_CHIP_LO      = 16'h8000;
   localparam logic [15:0] ON_CHIP_HI      = 16'h87FF;
   localparam logic [15:0] MEM_BASE        = 16'h8000;
   localparam logic [15:0] EVENT_ADDR      = 16'h8010;
   localparam logic [15:0] RESET_ENTRY_PTR = 16'h7FFE;
   localparam logic [15:0] MEM_START_OFS   = 16'h0012;
   localparam logic [15:0] MEM_START_ADDR  = 16'h8024;
   localparam int          SYS_WORDS       = 18;

   localparam int          CLK_HZ          = 50_000_000;
   localparam int          REF_HZ          = 5_000_000;
   localparam int          REF_DIV         = CLK_HZ / REF_HZ;
   localparam int          HI_TICK_US      = 1;
   localparam int          HI_TICK_CYC     = HI_TICK_US * (CLK_HZ / 1_000_000);
   localparam int          LO_TICK_US      = 64;
   localparam int          LO_TICK_CYC     = LO_TICK_US * (CLK_HZ / 1_000_000);
   localparam int          LO_TICKS_PER_S  = 15625;
   localparam int          SLICE_REF_CYC   = 5120;
   localparam int          SLICE_CYC       = SLICE_REF_CYC * REF_DIV;
   localparam int          HALT_SLICES     = 3;
   localparam int          HALT_CYC        = HALT_SLICES * SLICE_CYC;

   localparam logic [7:0]  CTRL_POKE       = 8'h00;
   localparam logic [7:0]  CTRL_PEEK       = 8'h01;

   typedef enum logic [1:0] {
      BAC_CMD_NONE,
      BAC_CMD_WRITE,
      BAC_CMD_READ,
      BAC_CMD_EXEC
   } bac_cmd_t;

   typedef struct packed {
      logic        valid;
      bac_cmd_t    cmd;
      logic [15:0] addr;
      logic [15:0] data;
   } bac_mem_req_t;

   typedef struct packed {
      logic        valid;
      logic [1:0]  link;
      logic [7:0]  data;
   } bac_byte_t;

endpackage : bac_pkg

/* hw/bac_event.sv */
`timescale 1ns/1ns
module bac_event (
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   input  wire logic req_pin_i,
   input  wire logic taker_ready_i,
   output logic      chan_ready_o,
   output logic      ack_o
);
   typedef struct packed {
      logic [2:0] sync;
      logic       level;
      logic       ready;
      logic       ack;
   } bac_ev_state_t;

   bac_ev_state_t st;
   bac_ev_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.sync = {st.sync[1:0], req_pin_i};
      if (st.sync[2] == st.sync[1]) begin
         next_st.level = st.sync[1];
      end
      // rising edge marks channel ready unless ack is still set, even with nobody waiting
      if (next_st.level && !st.level && !st.ack) begin
         next_st.ready = 1'b1;
      end
      if (st.ready && taker_ready_i) begin
         next_st.ack   = 1'b1;
         next_st.ready = 1'b0;
      end else if (st.ack && !st.level) begin
         next_st.ack = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign chan_ready_o = st.ready;
   assign ack_o        = st.ack;
endmodule : bac_event

/* hw/bac_boot.sv */
`timescale 1ns/1ns
module bac_boot (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              halt_req_i,
   input  wire logic              boot_source_select_i,
   input  wire logic              error_flag_i,
   input  wire logic              hi_proc_idle_i,
   input  wire logic              event_taker_ready_i,
   input  wire logic              event_taker_high_i,
   input  wire logic              event_request_in_i,
   input  wire bac_pkg::bac_byte_t rx_byte_i,
   input  wire logic              tx_ready_i,
   input  wire logic              tx_busy_i,
   input  wire logic              mem_ack_i,
   input  wire logic [15:0]       mem_rdata_i,
   output bac_pkg::bac_byte_t     tx_byte_o,
   output bac_pkg::bac_mem_req_t  mem_req_o,
   output logic                   mem_on_chip_o,
   output logic                   mem_reserved_o,
   output logic [3:0]             link_out_force_low_o,
   output logic                   refresh_en_o,
   output logic                   halted_o,
   output logic                   preempt_low_o,
   output logic                   error_o,
   output logic                   event_acknowledge_out_o,
   output logic                   event_chan_ready_o,
   output logic [15:0]            hi_timer_o,
   output logic [15:0]            lo_timer_o,
   output logic [15:0]            exec_addr_o,
   output logic [15:0]            workspace_o,
   output logic                   exec_start_o
);
   typedef enum logic [3:0] {
      S_IDLE, S_CTRL, S_ADDR_LO, S_ADDR_HI, S_DATA_LO, S_DATA_HI,
      S_MEM, S_TX_LO, S_TX_HI, S_LOAD, S_EXEC, S_RUN, S_HALTING, S_HALTED
   } bac_fsm_t;

   typedef struct packed {
      bac_fsm_t              fsm;
      logic [7:0]            ctrl;
      logic [1:0]            link;
      logic [15:0]           addr;
      logic [15:0]           data;
      logic [15:0]           count;
      logic [15:0]           hi_t;
      logic [15:0]           lo_t;
      logic [5:0]            hi_div;
      logic [11:0]           lo_div;
      logic [23:0]           halt_cnt;
      logic [2:0]            hsync;
      logic                  halt_lvl;
      logic                  inspect;
      bac_pkg::bac_mem_req_t req;
      bac_pkg::bac_byte_t    tx;
      logic [15:0]           exec_addr;
      logic [15:0]           ws;
      logic                  exec;
   } bac_state_t;

   bac_state_t st;
   bac_state_t next_st;
   logic       ev_ready;

   function automatic logic is_on_chip(input logic [15:0] a);
      is_on_chip = (a >= bac_pkg::ON_CHIP_LO) && (a <= bac_pkg::ON_CHIP_HI);
   endfunction : is_on_chip

   function automatic logic is_reserved(input logic [15:0] a);
      logic [15:0] ofs;
      ofs = (a - bac_pkg::MEM_BASE) >> 1;
      // channel words 0-17 inside the reserved region
      is_reserved = is_on_chip(a) && (ofs < bac_pkg::MEM_START_OFS);
   endfunction : is_reserved

   bac_event u_event (
      .ref_clk_i     (ref_clk_i),
      .rst_b_i       (rst_b_i),
      .req_pin_i     (event_request_in_i),
      .taker_ready_i (event_taker_ready_i),
      .chan_ready_o  (ev_ready),
      .ack_o         (event_acknowledge_out_o)
   );

   always_comb begin
      next_st      = st;
      next_st.exec = 1'b0;
      next_st.req.valid = 1'b0;
      if (tx_ready_i) begin
         next_st.tx.valid = 1'b0;
      end
      next_st.hsync = {st.hsync[1:0], halt_req_i};
      if (st.hsync[2] == st.hsync[1]) begin
         next_st.halt_lvl = st.hsync[1];
      end
      // timers
      if (st.hi_div == 6'(bac_pkg::HI_TICK_CYC - 1)) begin
         next_st.hi_div = '0;
         next_st.hi_t   = st.hi_t + 16'h0001;
      end else begin
         next_st.hi_div = st.hi_div + 6'h01;
      end
      if (st.lo_div == 12'(bac_pkg::LO_TICK_CYC - 1)) begin
         next_st.lo_div = '0;
         next_st.lo_t   = st.lo_t + 16'h0001;
      end else begin
         next_st.lo_div = st.lo_div + 12'h001;
      end
      // halt request edge, from any state unless the state case below moves fsm in the same cycle
      if (next_st.halt_lvl && !st.halt_lvl) begin
         next_st.fsm      = S_HALTING;
         next_st.halt_cnt = '0;
         next_st.inspect  = 1'b1;
      end
      case (st.fsm)
         S_IDLE: begin
            if (st.halt_lvl) begin
               next_st.fsm = S_HALTED;
            end else if (boot_source_select_i) begin
               next_st.exec_addr = bac_pkg::RESET_ENTRY_PTR;
               next_st.ws        = bac_pkg::MEM_START_ADDR;
               next_st.exec      = 1'b1;
               next_st.fsm       = S_RUN;
            end else begin
               next_st.fsm = S_CTRL;
            end
         end
         S_CTRL: begin
            if (rx_byte_i.valid) begin
               next_st.ctrl = rx_byte_i.data;
               next_st.link = rx_byte_i.link;
               next_st.addr = bac_pkg::MEM_START_ADDR;
               next_st.count = {8'h00, rx_byte_i.data};
               if (rx_byte_i.data == bac_pkg::CTRL_POKE || rx_byte_i.data == bac_pkg::CTRL_PEEK) begin
                  next_st.fsm = S_ADDR_LO;
               end else begin
                  next_st.fsm = S_LOAD;
               end
            end
         end
         S_ADDR_LO: begin
            if (rx_byte_i.valid && rx_byte_i.link == st.link) begin
               next_st.addr[7:0] = rx_byte_i.data;
               next_st.fsm       = S_ADDR_HI;
            end
         end
         S_ADDR_HI: begin
            if (rx_byte_i.valid && rx_byte_i.link == st.link) begin
               next_st.addr[15:8] = rx_byte_i.data;
               if (st.ctrl == bac_pkg::CTRL_POKE) begin
                  next_st.fsm = S_DATA_LO;
               end else begin
                  next_st.req = '{1'b1, bac_pkg::BAC_CMD_READ,
                                  {rx_byte_i.data, st.addr[7:0]}, 16'h0000};
                  next_st.fsm = S_MEM;
               end
            end
         end
         S_DATA_LO: begin
            if (rx_byte_i.valid && rx_byte_i.link == st.link) begin
               next_st.data[7:0] = rx_byte_i.data;
               next_st.fsm       = S_DATA_HI;
            end
         end
         S_DATA_HI: begin
            if (rx_byte_i.valid && rx_byte_i.link == st.link) begin
               next_st.req = '{1'b1, bac_pkg::BAC_CMD_WRITE, st.addr,
                               {rx_byte_i.data, st.data[7:0]}};
               next_st.fsm = S_MEM;
            end
         end
         S_MEM: begin
            next_st.req = st.req;
            if (mem_ack_i) begin
               next_st.req.valid = 1'b0;
               if (st.ctrl == bac_pkg::CTRL_PEEK) begin
                  next_st.data = mem_rdata_i;
                  next_st.fsm  = S_TX_LO;
               end else if (st.ctrl == bac_pkg::CTRL_POKE) begin
                  next_st.fsm = S_CTRL;
               end else if (st.count == 16'h0000) begin
                  next_st.fsm = S_EXEC;
               end else begin
                  next_st.fsm = S_LOAD;
               end
            end
         end
         S_TX_LO: begin
            if (!st.tx.valid) begin
               next_st.tx  = '{1'b1, st.link, st.data[7:0]};
               next_st.fsm = S_TX_HI;
            end
         end
         S_TX_HI: begin
            if (!st.tx.valid || tx_ready_i) begin
               next_st.tx  = '{1'b1, st.link, st.data[15:8]};
               next_st.fsm = S_CTRL;
            end
         end
         S_LOAD: begin
            if (rx_byte_i.valid && rx_byte_i.link == st.link) begin
               // byte write into code area, the byte copied into both halves of the data word
               next_st.req = '{1'b1, bac_pkg::BAC_CMD_WRITE, st.addr,
                               {rx_byte_i.data, rx_byte_i.data}};
               next_st.addr  = st.addr + 16'h0001;
               next_st.count = st.count - 16'h0001;
               next_st.fsm   = S_MEM;
            end
         end
         S_EXEC: begin
            next_st.exec_addr = bac_pkg::MEM_START_ADDR;
            next_st.ws        = st.addr + {15'h0000, st.addr[0]};
            next_st.req       = '{1'b1, bac_pkg::BAC_CMD_EXEC,
                                  bac_pkg::MEM_START_ADDR, 16'h0000};
            next_st.exec      = 1'b1;
            next_st.fsm       = S_RUN;
         end
         S_RUN: begin
            // the start request stands until memory takes it
            next_st.req = st.req;
            if (mem_ack_i) begin
               next_st.req.valid = 1'b0;
            end
         end
         S_HALTING: begin
            next_st.halt_cnt = st.halt_cnt + 24'h00_0001;
            if ((st.halt_cnt >= 24'(bac_pkg::HALT_CYC - 1) || hi_proc_idle_i) && !tx_busy_i) begin
               next_st.fsm = S_HALTED;
            end
         end
         S_HALTED: begin
            if (!st.halt_lvl) begin
               next_st.fsm = S_IDLE;
            end
         end
         default: begin
            next_st.fsm = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st     <= '0;
         st.fsm <= S_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign error_o              = error_flag_i;
   assign preempt_low_o        = ev_ready & event_taker_ready_i & event_taker_high_i;
   assign event_chan_ready_o   = ev_ready;
   assign mem_on_chip_o        = is_on_chip(st.req.addr);
   assign mem_reserved_o       = is_reserved(st.req.addr);
   assign link_out_force_low_o = {4{~rst_b_i}};
   assign refresh_en_o         = 1'b1;
   assign halted_o             = (st.fsm == S_HALTED);
   assign tx_byte_o            = st.tx;
   assign mem_req_o            = st.req;
   assign hi_timer_o           = st.hi_t;
   assign lo_timer_o           = st.lo_t;
   assign exec_addr_o          = st.exec_addr;
   assign workspace_o          = st.ws;
   assign exec_start_o         = st.exec;
endmodule : bac_boot

/* verification/bac_boot_monitor.sv */
`timescale 1ns/1ns
module bac_boot_monitor (
   input wire logic                  ref_clk_i,
   input wire logic                  rst_b_i,
   input wire logic                  error_flag_i,
   input wire logic                  event_taker_ready_i,
   input wire logic                  event_request_in_i,
   input wire logic                  tx_ready_i,
   input wire logic                  mem_ack_i,
   input wire bac_pkg::bac_byte_t    tx_byte_o,
   input wire bac_pkg::bac_mem_req_t mem_req_o,
   input wire logic                  mem_on_chip_o,
   input wire logic                  mem_reserved_o,
   input wire logic                  refresh_en_o,
   input wire logic                  error_o,
   input wire logic                  event_acknowledge_out_o,
   input wire logic                  event_chan_ready_o,
   input wire logic [15:0]           hi_timer_o,
   input wire logic [15:0]           exec_addr_o,
   input wire logic [15:0]           workspace_o,
   input wire logic                  exec_start_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   property p_err; error_o == error_flag_i; endproperty
   a_err: assert property (p_err) else $error("error pin off flag");
   property p_ref; refresh_en_o; endproperty
   a_ref: assert property (p_ref) else $error("refresh stopped");
   property p_mem_hold; mem_req_o.valid && !mem_ack_i |=> $stable(mem_req_o); endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("mem request moved");
   property p_tx_hold; tx_byte_o.valid && !tx_ready_i |=> $stable(tx_byte_o); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved");
   property p_chip;
      mem_req_o.valid |-> mem_on_chip_o == (mem_req_o.addr >= 16'h8000 && mem_req_o.addr <= 16'h87ff);
   endproperty
   a_chip: assert property (p_chip) else $error("on chip decode wrong");
   property p_resv;
      mem_req_o.valid |-> mem_reserved_o == (mem_req_o.addr >= 16'h8000 && mem_req_o.addr < 16'h8024);
   endproperty
   a_resv: assert property (p_resv) else $error("reserved decode wrong");
   property p_exec;
      exec_start_o |-> ((exec_addr_o == 16'h7ffe) ? (workspace_o == 16'h8024)
                                                  : (exec_addr_o == 16'h8024));
   endproperty
   a_exec: assert property (p_exec) else $error("bad start point");
   property p_ack_rise;
      $rose(event_acknowledge_out_o) |-> $past(event_taker_ready_i) && $past(event_chan_ready_o);
   endproperty
   a_ack_rise: assert property (p_ack_rise) else $error("ack without ready pair");
   property p_ack_fall;
      event_acknowledge_out_o && $fell(event_request_in_i) |-> ##[1:6] !event_acknowledge_out_o;
   endproperty
   a_ack_fall: assert property (p_ack_fall) else $error("ack stuck high");
   property p_rdy; $rose(event_request_in_i) |-> ##[1:6] event_chan_ready_o; endproperty
   a_rdy: assert property (p_rdy) else $error("event not made ready");
   property p_hi; $changed(hi_timer_o) |-> hi_timer_o == $past(hi_timer_o) + 16'h0001; endproperty
   a_hi: assert property (p_hi) else $error("high timer jumped");
   c_exec: cover property (exec_start_o);
   c_ack: cover property ($rose(event_acknowledge_out_o));
   c_read: cover property (mem_req_o.valid && mem_ack_i && mem_req_o.cmd == bac_pkg::BAC_CMD_READ);
endmodule : bac_boot_monitor

bind bac_boot bac_boot_monitor bac_boot_monitor_i (.ref_clk_i, .rst_b_i, .error_flag_i,
   .event_taker_ready_i, .event_request_in_i, .tx_ready_i, .mem_ack_i, .tx_byte_o, .mem_req_o,
   .mem_on_chip_o, .mem_reserved_o, .refresh_en_o, .error_o, .event_acknowledge_out_o,
   .event_chan_ready_o, .hi_timer_o, .exec_addr_o, .workspace_o, .exec_start_o);

/* verification/bac_host_model.sv */
`timescale 1ns/1ns
module bac_host_model #(
   parameter int MEM_DLY = 2,
   parameter int TX_DLY  = 3
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   input  wire bac_pkg::bac_mem_req_t mem_req_i,
   input  wire bac_pkg::bac_byte_t    tx_byte_i,
   output logic                       mem_ack_o,
   output logic [15:0]                mem_rdata_o,
   output logic                       tx_ready_o
);
   int mc;
   int tc;
   // read data is only meaningful with ack; it toggles otherwise
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mem_ack_o <= 1'b0;
         tx_ready_o <= 1'b0;
         mem_rdata_o <= 16'h0000;
         mc <= 0;
         tc <= 0;
      end else begin
         mem_ack_o <= 1'b0;
         tx_ready_o <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o;
         if (mem_req_i.valid && !mem_ack_o) begin
            mc <= mc + 1;
            if (mc == MEM_DLY) begin
               mem_ack_o <= 1'b1;
               mem_rdata_o <= mem_req_i.addr ^ 16'h5a3c;
               mc <= 0;
            end
         end
         if (tx_byte_i.valid && !tx_ready_o) begin
            tc <= tc + 1;
            if (tc == TX_DLY) begin
               tx_ready_o <= 1'b1;
               tc <= 0;
            end
         end
      end
   end
endmodule : bac_host_model

/* verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   logic ref_clk_i = 0, rst_b_i = 0, halt_req_i = 0, boot_source_select_i = 0, error_flag_i = 0;
   logic hi_proc_idle_i = 1, event_taker_ready_i = 0, event_taker_high_i = 0, tx_busy_i = 0;
   logic event_request_in_i = 0, tx_ready_i, mem_ack_i, mem_on_chip_o, mem_reserved_o;
   logic refresh_en_o, halted_o, preempt_low_o, error_o, exec_start_o;
   logic event_acknowledge_out_o, event_chan_ready_o;
   logic [3:0]  link_out_force_low_o;
   logic [15:0] mem_rdata_i, hi_timer_o, lo_timer_o, exec_addr_o, workspace_o;
   bac_pkg::bac_byte_t    rx_byte_i = '0;
   bac_pkg::bac_byte_t    tx_byte_o;
   bac_pkg::bac_mem_req_t mem_req_o;
   int err_total = 0;
   int cmp_count = 0;
   bac_boot bac_boot_i (.ref_clk_i, .rst_b_i, .halt_req_i, .boot_source_select_i, .error_flag_i,
      .hi_proc_idle_i, .event_taker_ready_i, .event_taker_high_i, .event_request_in_i,
      .rx_byte_i, .tx_ready_i, .tx_busy_i, .mem_ack_i, .mem_rdata_i, .tx_byte_o, .mem_req_o,
      .mem_on_chip_o, .mem_reserved_o, .link_out_force_low_o, .refresh_en_o, .halted_o,
      .preempt_low_o, .error_o, .event_acknowledge_out_o, .event_chan_ready_o, .hi_timer_o,
      .lo_timer_o, .exec_addr_o, .workspace_o, .exec_start_o);
   bac_host_model bac_host_model_i (.clk_i(ref_clk_i), .rst_b_i, .mem_req_i(mem_req_o),
      .tx_byte_i(tx_byte_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i),
      .tx_ready_o(tx_ready_i));
   initial forever #10 ref_clk_i = ~ref_clk_i;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wrap_up;
      $display("mismatches=%0d compares=%0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   task do_reset(input logic sel);
      @(negedge ref_clk_i);
      rst_b_i = 0;
      boot_source_select_i = sel;
      rx_byte_i = '0;
      repeat (12) @(negedge ref_clk_i);
      chk(link_out_force_low_o, 4'hf);
      rst_b_i = 1;
      @(negedge ref_clk_i);
   endtask : do_reset
   task send(input logic [1:0] l, input logic [7:0] d);
      @(negedge ref_clk_i);
      rx_byte_i = {1'b1, l, d};
      @(negedge ref_clk_i);
      rx_byte_i = '0;
   endtask : send
   task mem_exp(input bac_pkg::bac_cmd_t c, input logic [15:0] a, d, input logic use_d);
      for (int i = 0; i < 40 && !mem_req_o.valid; i++) @(negedge ref_clk_i);
      chk({mem_req_o.valid, mem_req_o.cmd}, {1'b1, c});
      chk(mem_req_o.addr, a);
      if (use_d) chk(mem_req_o.data, d);
      for (int i = 0; i < 40 && !mem_ack_i; i++) @(negedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask : mem_exp
   task tx_exp(input logic [1:0] l, input logic [7:0] d);
      for (int i = 0; i < 40 && !(tx_byte_o.valid && tx_ready_i); i++) @(negedge ref_clk_i);
      chk({tx_byte_o.valid, tx_byte_o.link, tx_byte_o.data}, {1'b1, l, d});
      @(negedge ref_clk_i);
   endtask : tx_exp
   task wait_exec(input logic [15:0] a, w);
      for (int i = 0; i < 20 && !exec_start_o; i++) @(negedge ref_clk_i);
      chk(exec_start_o, 1'b1);
      chk(exec_addr_o, a);
      chk(workspace_o, w);
   endtask : wait_exec
   task t_poke;
      send(2'd3, 8'h00);
      send(2'd3, 8'h10);
      send(2'd0, 8'h77); // other link ignored mid command
      send(2'd3, 8'h80);
      send(2'd3, 8'hcd);
      send(2'd3, 8'hab);
      mem_exp(bac_pkg::BAC_CMD_WRITE, 16'h8010, 16'habcd, 1'b1);
   endtask : t_poke
   task t_peek;
      logic [15:0] e;
      e = 16'h8008 ^ 16'h5a3c;
      send(2'd2, 8'h01);
      send(2'd2, 8'h08);
      send(2'd2, 8'h80);
      mem_exp(bac_pkg::BAC_CMD_READ, 16'h8008, 16'h0000, 1'b0);
      tx_exp(2'd2, e[7:0]);
      tx_exp(2'd2, e[15:8]);
   endtask : t_peek
   task t_event;
      @(negedge ref_clk_i);
      event_request_in_i = 1;
      for (int i = 0; i < 10 && !event_chan_ready_o; i++) @(negedge ref_clk_i);
      chk(event_chan_ready_o, 1'b1);
      chk(event_acknowledge_out_o, 1'b0);
      event_taker_ready_i = 1;
      event_taker_high_i = 1;
      #1 chk(preempt_low_o, 1'b1);
      for (int i = 0; i < 10 && !event_acknowledge_out_o; i++) @(negedge ref_clk_i);
      chk(event_acknowledge_out_o, 1'b1);
      event_taker_ready_i = 0;
      event_request_in_i = 0;
      for (int i = 0; i < 10 && event_acknowledge_out_o; i++) @(negedge ref_clk_i);
      chk(event_acknowledge_out_o, 1'b0);
   endtask : t_event
   task t_timer;
      logic [15:0] h;
      @(negedge ref_clk_i);
      h = hi_timer_o;
      repeat (bac_pkg::HI_TICK_CYC) @(negedge ref_clk_i);
      chk(hi_timer_o, h + 16'h0001);
      h = lo_timer_o;
      repeat (bac_pkg::LO_TICK_CYC) @(negedge ref_clk_i);
      chk(lo_timer_o, h + 16'h0001);
   endtask : t_timer
   task t_err;
      @(negedge ref_clk_i);
      error_flag_i = 1;
      #1 chk(error_o, 1'b1);
      error_flag_i = 0;
      #1 chk(error_o, 1'b0);
   endtask : t_err
   task t_load;
      send(2'd1, 8'h02);
      send(2'd1, 8'h5e);
      mem_exp(bac_pkg::BAC_CMD_WRITE, 16'h8024, 16'h5e5e, 1'b1);
      send(2'd1, 8'h7a);
      mem_exp(bac_pkg::BAC_CMD_WRITE, 16'h8025, 16'h7a7a, 1'b1);
      wait_exec(16'h8024, 16'h8026);
   endtask : t_load
   task t_abort;
      do_reset(1'b0);
      send(2'd0, 8'h00);
      send(2'd0, 8'h12);
      do_reset(1'b1);
      wait_exec(16'h7ffe, 16'h8024);
      chk(mem_req_o.valid, 1'b0);
   endtask : t_abort
   task t_halt;
      @(negedge ref_clk_i);
      halt_req_i = 1;
      for (int i = 0; i < 20 && !halted_o; i++) @(negedge ref_clk_i);
      chk(halted_o, 1'b1);
      do_reset(1'b1);
      halt_req_i = 0;
      wait_exec(16'h7ffe, 16'h8024);
   endtask : t_halt
   initial begin
      do_reset(1'b0);
      t_poke;
      t_peek;
      t_event;
      t_timer;
      t_err;
      t_load;
      t_abort;
      t_halt;
      wrap_up;
   end
   // the tests need about 3400 cycles; this cuts a hang well after that
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      err_total++;
      wrap_up;
   end
endmodule : tb_top
